/* mmdec_pkg.sv */
/*
 * mmdec_pkg: constants for the 1 Mbyte memory map decoder.
 * assumes: 20-bit byte addresses from the cpu core, one system clock.
 */
package mmdec_pkg;
    localparam int unsigned ADDR_W = 20;

    typedef enum logic [1:0] {
        MMDEC_VAR_SMALL,
        MMDEC_VAR_MID,
        MMDEC_VAR_LARGE
    } mmdec_variant_t;

    typedef enum logic [1:0] {
        MMDEC_TGT_NONE,
        MMDEC_TGT_ROM,
        MMDEC_TGT_DATA,
        MMDEC_TGT_EXT
    } mmdec_target_t;

    // ****************************************
    // map base codes carried by the base select instruction
    // ****************************************
    localparam logic [3:0] BASE_LOW = 4'h0;
    localparam logic [3:0] BASE_TOP = 4'hf;

    // ****************************************
    // data area starts, low base then top base
    // ****************************************
    localparam logic [19:0] DATA_LO_SMALL = 20'h0_f100;
    localparam logic [19:0] DATA_LO_MID   = 20'h0_eb00;
    localparam logic [19:0] DATA_LO_LARGE = 20'h0_df00;
    localparam logic [19:0] DATA_LO_END   = 20'h0_ffff;
    localparam logic [19:0] DATA_HI_SMALL = 20'hf_f100;
    localparam logic [19:0] DATA_HI_MID   = 20'hf_eb00;
    localparam logic [19:0] DATA_HI_LARGE = 20'hf_df00;
    localparam logic [19:0] DATA_HI_END   = 20'hf_ffff;

    // ****************************************
    // last internal rom address per variant
    // ****************************************
    localparam logic [19:0] ROM_END_SMALL = 20'h1_7fff;
    localparam logic [19:0] ROM_END_BIG   = 20'h1_ffff;

    // reset entry window in the low base area
    localparam logic [19:0] VEC_END = 20'h0_00ff;
endpackage

/* mmdec_range.sv */
/*
 * mmdec_range: classifies one address against the current map.
 * assumes: variant and base are stable while addresses are decoded.
 */
`timescale 1ns/1ps
`default_nettype none
module mmdec_range (
    // map selection
    input  wire logic [1:0]  variant,
    input  wire logic        base_top,
    input  wire logic        ext_mode,
    // address in, class out
    input  wire logic [19:0] addr,
    output logic [1:0]       target
);
    logic [19:0] data_start;
    logic [19:0] data_end;
    logic [19:0] rom_end;
    logic        in_data;
    logic        in_rom;

    always_comb begin
        case (variant)
            mmdec_pkg::MMDEC_VAR_SMALL: data_start = base_top ? mmdec_pkg::DATA_HI_SMALL : mmdec_pkg::DATA_LO_SMALL;
            mmdec_pkg::MMDEC_VAR_MID:   data_start = base_top ? mmdec_pkg::DATA_HI_MID : mmdec_pkg::DATA_LO_MID;
            default:                    data_start = base_top ? mmdec_pkg::DATA_HI_LARGE : mmdec_pkg::DATA_LO_LARGE;
        endcase
    end
    assign data_end = base_top ? mmdec_pkg::DATA_HI_END : mmdec_pkg::DATA_LO_END;
    assign rom_end  = (variant == mmdec_pkg::MMDEC_VAR_SMALL) ? mmdec_pkg::ROM_END_SMALL
                                                              : mmdec_pkg::ROM_END_BIG;
    // data area wins over the rom lying underneath it
    assign in_data  = (addr >= data_start) && (addr <= data_end);
    assign in_rom   = (addr <= rom_end) && !in_data;
    assign target   = in_data ? mmdec_pkg::MMDEC_TGT_DATA :
                      in_rom  ? mmdec_pkg::MMDEC_TGT_ROM  :
                      ext_mode ? mmdec_pkg::MMDEC_TGT_EXT : mmdec_pkg::MMDEC_TGT_NONE;
endmodule
`default_nettype wire

/* mmdec_top.sv */
/*
 * mmdec_top: memory map decoder, registered region selects.
 * assumes: cpu core on clk_sys issues the base select instruction once
 * after reset; ext_mode is a same-domain level from the mode logic.
 */
`timescale 1ns/1ps
`default_nettype none
module mmdec_top #(
    parameter logic [1:0] VARIANT = mmdec_pkg::MMDEC_VAR_LARGE
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // base select instruction from the core
    input  wire logic        map_base_select_instruction,
    input  wire logic [3:0]  map_base_code,
    // access request
    input  wire logic        acc_valid,
    input  wire logic        acc_reset_fetch,
    input  wire logic [19:0] acc_addr,
    input  wire logic        ext_mode,
    // region selects, one cycle after the request
    output logic             sel_rom,
    output logic             sel_data,
    output logic             sel_ext,
    output logic             sel_none,
    output logic [19:0]      sel_addr,
    // map state
    output logic             base_locked,
    output logic             base_top,
    output logic             reselect_err
);
    // ****************************************
    // base latch
    // ****************************************
    logic       next_locked;
    logic       next_top;
    logic       take_sel;
    logic [1:0] target;
    logic [1:0] eff_target;
    logic       vec_ok;

    assign take_sel    = map_base_select_instruction && !base_locked;
    assign next_locked = base_locked || map_base_select_instruction;
    // any code other than the top one keeps the low base
    assign next_top    = take_sel ? (map_base_code == mmdec_pkg::BASE_TOP) : base_top;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            base_locked  <= 1'b0;
            base_top     <= 1'b0;
            reselect_err <= 1'b0;
        end else begin
            base_locked  <= next_locked;
            base_top     <= next_top;
            // sticky flag for a second select, which is otherwise ignored
            reselect_err <= reselect_err || (map_base_select_instruction && base_locked);
        end
    end

    // ****************************************
    // decode
    // ****************************************
    mmdec_range u_range (
        .variant  (VARIANT),
        .base_top (base_top),
        .ext_mode (ext_mode),
        .addr     (acc_addr),
        .target   (target)
    );

    // reset fetch is forced to rom inside the entry window and to none above it, so ram is never used
    assign vec_ok     = acc_addr <= mmdec_pkg::VEC_END;
    assign eff_target = (acc_reset_fetch && !vec_ok) ? mmdec_pkg::MMDEC_TGT_NONE :
                        acc_reset_fetch ? mmdec_pkg::MMDEC_TGT_ROM : target;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sel_rom  <= 1'b0;
            sel_data <= 1'b0;
            sel_ext  <= 1'b0;
            sel_none <= 1'b0;
            sel_addr <= 20'h0_0000;
        end else begin
            sel_rom  <= acc_valid && (eff_target == mmdec_pkg::MMDEC_TGT_ROM);
            sel_data <= acc_valid && (eff_target == mmdec_pkg::MMDEC_TGT_DATA);
            sel_ext  <= acc_valid && (eff_target == mmdec_pkg::MMDEC_TGT_EXT);
            sel_none <= acc_valid && (eff_target == mmdec_pkg::MMDEC_TGT_NONE);
            sel_addr <= acc_addr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // ****************************************
    // map figures for the checks
    // ****************************************
    // taken per variant from the package, not from the range decoder,
    // so a slip inside the decoder cannot hide behind its own numbers
    logic [19:0] low_start;
    logic [19:0] top_start;
    logic [19:0] rom_last;

    assign low_start = (VARIANT == mmdec_pkg::MMDEC_VAR_SMALL) ? mmdec_pkg::DATA_LO_SMALL :
                       (VARIANT == mmdec_pkg::MMDEC_VAR_MID)   ? mmdec_pkg::DATA_LO_MID   :
                                                                 mmdec_pkg::DATA_LO_LARGE;
    assign top_start = (VARIANT == mmdec_pkg::MMDEC_VAR_SMALL) ? mmdec_pkg::DATA_HI_SMALL :
                       (VARIANT == mmdec_pkg::MMDEC_VAR_MID)   ? mmdec_pkg::DATA_HI_MID   :
                                                                 mmdec_pkg::DATA_HI_LARGE;
    assign rom_last  = (VARIANT == mmdec_pkg::MMDEC_VAR_SMALL) ? mmdec_pkg::ROM_END_SMALL
                                                               : mmdec_pkg::ROM_END_BIG;

    sequence s_req_data;
        acc_valid && !acc_reset_fetch && (target == mmdec_pkg::MMDEC_TGT_DATA);
    endsequence

    sequence s_plain_acc;
        acc_valid && !acc_reset_fetch;
    endsequence

    sequence s_reset_fetch;
        acc_valid && acc_reset_fetch;
    endsequence

    sequence s_first_sel;
        map_base_select_instruction && !base_locked;
    endsequence

    sequence s_second_sel;
        map_base_select_instruction && base_locked;
    endsequence

    AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $onehot0({sel_rom, sel_data, sel_ext, sel_none}) && ($past(acc_valid) == (sel_rom | sel_data | sel_ext | sel_none)))
        else $error("select not unique");
    AST_LOW_SMALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (VARIANT == mmdec_pkg::MMDEC_VAR_SMALL) && !base_top && acc_valid && !acc_reset_fetch
        && acc_addr >= 20'h0_f100 && acc_addr <= 20'h0_ffff |=> sel_data)
        else $error("small low data area missed");
    AST_LOW_MID: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (VARIANT == mmdec_pkg::MMDEC_VAR_MID) && !base_top && acc_valid && !acc_reset_fetch
        && acc_addr == 20'h0_eb00 |=> sel_data)
        else $error("mid low data start missed");
    AST_LOW_LARGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (VARIANT == mmdec_pkg::MMDEC_VAR_LARGE) && !base_top && acc_valid && !acc_reset_fetch
        && acc_addr == 20'h0_deff |=> sel_rom)
        else $error("rom below large data area lost");
    AST_TOP_DATA: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_req_data and base_top |-> acc_addr[19:16] == 4'hf)
        else $error("top base data area not at top");
    AST_ROM_SIZE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        base_top && acc_valid && !acc_reset_fetch && acc_addr == 20'h0_f800 |=> sel_rom)
        else $error("hidden rom not usable under top base");
    AST_ROM_END: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc_valid && !acc_reset_fetch && acc_addr == 20'h1_ffff
        && (VARIANT != mmdec_pkg::MMDEC_VAR_SMALL) |=> sel_rom)
        else $error("rom end missed");
    AST_EXT_GATE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sel_ext |-> $past(ext_mode))
        else $error("external access outside expansion mode");
    AST_VEC: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc_valid && acc_reset_fetch |=> !sel_data)
        else $error("reset entry fetched from data area");
    AST_LOCK: assert property (@(posedge clk_sys) disable iff (sys_rst)
        base_locked |=> $stable(base_top) && base_locked)
        else $error("base changed after lock");

    // ****************************************
    // region checks for both bases
    // ****************************************
    AST_LOW_ROM: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (!base_top && acc_addr < low_start) |=> sel_rom)
        else $error("rom below low data area lost");
    AST_LOW_DATA: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (!base_top && acc_addr >= low_start && acc_addr <= mmdec_pkg::DATA_LO_END) |=> sel_data)
        else $error("low data area missed");
    AST_LOW_TAIL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (!base_top && acc_addr > mmdec_pkg::DATA_LO_END && acc_addr <= rom_last) |=> sel_rom)
        else $error("rom above low data area lost");
    AST_TOP_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (base_top && acc_addr >= top_start) |=> sel_data)
        else $error("top data area missed");
    AST_TOP_ROM: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (base_top && acc_addr <= rom_last) |=> sel_rom)
        else $error("rom not contiguous under top base");
    AST_GAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_plain_acc and (acc_addr > rom_last && acc_addr < top_start)
        |=> (sel_ext == $past(ext_mode)) && (sel_none != $past(ext_mode)))
        else $error("unmapped address routed wrongly");
    AST_ADDR_COPY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc_valid |=> sel_addr == $past(acc_addr))
        else $error("select address not the request address");

    // ****************************************
    // reset entry checks
    // ****************************************
    AST_VEC_ROM: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_reset_fetch and (acc_addr <= mmdec_pkg::VEC_END) |=> sel_rom)
        else $error("reset entry not from rom");
    AST_VEC_FAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_reset_fetch and (acc_addr > mmdec_pkg::VEC_END) |=> sel_none)
        else $error("reset entry outside its window accepted");

    // ****************************************
    // base selection checks
    // ****************************************
    AST_FIRST_SEL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_first_sel |=> base_locked && (base_top == ($past(map_base_code) == mmdec_pkg::BASE_TOP)))
        else $error("first base select not taken");
    AST_NO_LOCK: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !base_locked && !map_base_select_instruction |=> !base_locked && !base_top)
        else $error("base moved without a select");
    AST_RESEL_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_second_sel |=> reselect_err)
        else $error("second select not flagged");
    AST_RESEL_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reselect_err |=> reselect_err)
        else $error("reselect flag dropped");
    AST_RESEL_CLEAN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !base_locked |-> !reselect_err)
        else $error("reselect flag without a lock");
endmodule
`default_nettype wire

/* mmdec_cpu_model.sv */
/*
 * mmdec_cpu_model: core side of the decoder, issues accesses and base selects.
 * assumes: the bench calls drive at most once per clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module mmdec_cpu_model (
    // clock
    input  wire logic        clk_sys,
    // requests to the decoder
    output var  logic        map_base_select_instruction,
    output var  logic [3:0]  map_base_code,
    output var  logic        acc_valid,
    output var  logic        acc_reset_fetch,
    output var  logic [19:0] acc_addr,
    output var  logic        ext_mode
);
    initial begin
        map_base_select_instruction = 1'b0;
        map_base_code = 4'h0;
        acc_valid = 1'b0;
        acc_reset_fetch = 1'b0;
        acc_addr = 20'h0_0000;
        ext_mode = 1'b0;
    end

    task automatic drive(input logic v, rf, e, input logic [19:0] a, input logic s, input logic [3:0] c);
        @(posedge clk_sys);
        acc_valid <= v;
        acc_reset_fetch <= rf;
        ext_mode <= e;
        // idle address keeps moving so nothing leans on a stale value
        acc_addr <= v ? a : ~acc_addr;
        map_base_select_instruction <= s;
        map_base_code <= c;
    endtask
endmodule
`default_nettype wire

/* mmdec_tb_top.sv */
/*
 * mmdec_tb_top: checks all three size variants side by side.
 * assumes: one 100 MHz clock, sync reset, results one cycle after request.
 */
`timescale 1ns/1ps
`default_nettype none
module mmdec_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic top_sel = 1'b0;
    logic locked = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    logic [23:0] q [3][$];
    logic [19:0] tbl [23] = '{20'h0_0000, 20'h0_00ff, 20'h0_0100, 20'h0_deff, 20'h0_df00, 20'h0_eaff,
        20'h0_eb00, 20'h0_f0ff, 20'h0_f100, 20'h0_f800, 20'h0_ffff, 20'h1_0000, 20'h1_7fff, 20'h1_8000, 20'h1_ffff,
        20'h2_0000, 20'hf_deff, 20'hf_df00, 20'hf_eaff, 20'hf_eb00, 20'hf_f0ff, 20'hf_f100, 20'hf_ffff};
    wire s, v, rf, e;
    wire [3:0] c;
    wire [19:0] a;
    wire [3:0] hot [3];
    wire [19:0] sa [3];
    wire lk [3], tp [3], er [3];

    always #5 clk_sys = ~clk_sys;

    mmdec_cpu_model cpu (.clk_sys(clk_sys), .map_base_select_instruction(s), .map_base_code(c),
        .acc_valid(v), .acc_reset_fetch(rf), .acc_addr(a), .ext_mode(e));

    task automatic chk(input logic [23:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    for (genvar i = 0; i < 3; i++) begin : g_var
        mmdec_top #(.VARIANT(2'(i))) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
            .map_base_select_instruction(s), .map_base_code(c), .acc_valid(v), .acc_reset_fetch(rf),
            .acc_addr(a), .ext_mode(e), .sel_rom(hot[i][1]), .sel_data(hot[i][2]), .sel_ext(hot[i][3]),
            .sel_none(hot[i][0]), .sel_addr(sa[i]), .base_locked(lk[i]), .base_top(tp[i]),
            .reselect_err(er[i]));
        always @(negedge clk_sys) begin
            if (hot[i] !== 4'h0) begin
                if (q[i].size() == 0) chk(24'h00_0000, {sa[i], hot[i]});
                else chk(q[i].pop_front(), {sa[i], hot[i]});
            end
        end
    end

    // ****************************************
    // expected map, one-hot {ext, data, rom, none}
    // ****************************************
    function automatic logic [3:0] hot_of(int vr, logic t, x, f, logic [19:0] ad);
        logic [19:0] lo;
        lo = (vr == 0) ? 20'h0_f100 : (vr == 1) ? 20'h0_eb00 : 20'h0_df00;
        lo[19:16] = t ? 4'hf : 4'h0;
        if (f) return (ad <= 20'h0_00ff) ? 4'h2 : 4'h1;
        if (ad >= lo && ad <= {lo[19:16], 16'hffff}) return 4'h4;
        if (ad <= ((vr == 0) ? 20'h1_7fff : 20'h1_ffff)) return 4'h2;
        return x ? 4'h8 : 4'h1;
    endfunction

    task automatic acc(input logic f, x, input logic [19:0] ad);
        for (int i = 0; i < 3; i++) q[i].push_back({ad, hot_of(i, top_sel, x, f, ad)});
        cpu.drive(1'b1, f, x, ad, 1'b0, 4'h0);
    endtask

    task automatic sweep();
        foreach (tbl[k]) for (int m = 0; m < 4; m++) acc(m[1], m[0], tbl[k]);
        repeat (30) acc(1'b0, 1'($urandom), 20'($urandom));
    endtask

    task automatic sel(input logic [3:0] cd);
        if (!locked) top_sel = (cd == 4'hf);
        locked = 1'b1;
        cpu.drive(1'b0, 1'b0, 1'b0, 20'h0_0000, 1'b1, cd);
    endtask

    task automatic stat(input logic [2:0] exp);
        cpu.drive(1'b0, 1'b0, 1'b0, 20'h0_0000, 1'b0, 4'h0);
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 3; i++) chk({21'h0, exp}, {21'h0, lk[i], tp[i], er[i]});
    endtask

    task automatic finish_test();
        for (int i = 0; i < 3; i++) miscompares += q[i].size();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(32'ha414));
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        sweep();
        stat(3'b000);
        sel(4'hf);
        sweep();
        stat(3'b110);
        sel(4'h0);
        sweep();
        stat(3'b111);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        locked = 1'b0;
        sel(4'h0);
        sweep();
        stat(3'b100);
        finish_test();
    end
endmodule
`default_nettype wire
